// ---- inc/itc_defines.vh ----
`ifndef ITC_DEFINES_VH
`define ITC_DEFINES_VH

// ----------------------------------------------------------------
// channel count and register offsets (byte addresses)
// ----------------------------------------------------------------
`define ITC_NCH          4
`define ITC_OFS_CMP      12'h000
`define ITC_OFS_MODE     12'h010
`define ITC_OFS_CNT      12'h020
`define ITC_OFS_LVL      12'h030
`define ITC_OFS_GATE     12'h034
`define ITC_OFS_START    12'h038
`define ITC_OFS_STOP     12'h03c
`define ITC_OFS_ENST     12'h040
`define ITC_OFS_FLAG     12'h044
`define ITC_OFS_MASK     12'h048

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ITC_MODE_MD_HI   3
`define ITC_MODE_MD0     0
`define ITC_MODE_CCS     12
`define ITC_MODE_CKS_LO  14
`define ITC_MODE_CKS_HI  15
`define ITC_FLAG_LSB     4
`define ITC_FLAG_MSB     7

// ----------------------------------------------------------------
// mode codes of md[3:1]
// ----------------------------------------------------------------
`define ITC_MD_INTV      3'h0
`define ITC_MD_CAPT      3'h2
`define ITC_MD_ONEC      3'h4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ITC_RST_CMP      16'h0000
`define ITC_RST_MODE     16'h0000
`define ITC_RST_LVL      4'h0
`define ITC_RST_GATE     4'h0
`define ITC_RST_FLAG     4'h0
`define ITC_RST_MASK     4'hf

// ----------------------------------------------------------------
// operation clock taps: tick when masked prescaler bits are all one
// ----------------------------------------------------------------
`define ITC_TAP0         16'h0000
`define ITC_TAP1         16'h0003
`define ITC_TAP2         16'h000f
`define ITC_TAP3         16'h00ff

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define ITC_RESP_OKAY    2'h0
`define ITC_RESP_SLVERR  2'h2

`endif

// ---- hw/itc_chan.v ----
`include "itc_defines.vh"

module itc_chan (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        tick,
  input  wire        start,
  input  wire        stop,
  input  wire        trig,
  input  wire [3:0]  mode,
  input  wire [15:0] cmp,
  output wire [15:0] cnt,
  output wire        en,
  output reg         expire,
  output reg         start_evt,
  output reg         set_o,
  output reg         clr_o,
  output reg         tog_o
);

  reg [15:0] cnt_ff;
  reg        en_ff;
  reg        run_ff;
  reg [15:0] nxt_cnt;
  reg        nxt_en;
  reg        nxt_run;

  assign cnt = cnt_ff;
  assign en  = en_ff;

  // ----------------------------------------------------------------
  // count engine: mode decides when the counter really moves
  // ----------------------------------------------------------------
  always @* begin
    nxt_cnt   = cnt_ff;
    nxt_en    = en_ff;
    nxt_run   = run_ff;
    expire    = 1'b0;
    start_evt = 1'b0;
    set_o     = 1'b0;
    clr_o     = 1'b0;
    tog_o     = 1'b0;
    if (stop) begin
      nxt_en  = 1'b0;
      nxt_run = 1'b0;
    end else if (start) begin
      nxt_en = 1'b1; // R07
      case (mode[`ITC_MODE_MD_HI:1])
        `ITC_MD_INTV: begin
          nxt_cnt   = cmp; // R09
          nxt_run   = 1'b1;
          start_evt = mode[`ITC_MODE_MD0]; // R12
          tog_o     = mode[`ITC_MODE_MD0]; // R12
        end
        `ITC_MD_CAPT: begin
          nxt_cnt   = 16'h0000;
          nxt_run   = 1'b1;
          start_evt = mode[`ITC_MODE_MD0];
        end
        default: begin
          nxt_run = 1'b0; // one-count waits for the master
        end
      endcase
    end else if (en_ff) begin
      case (mode[`ITC_MODE_MD_HI:1])
        `ITC_MD_INTV: begin
          if (run_ff && tick) begin
            if (cnt_ff == 16'h0000) begin
              nxt_cnt = cmp; // R14
              expire  = 1'b1; // R01
              tog_o   = 1'b1;
            end else begin
              nxt_cnt = cnt_ff - 16'h0001; // R11
            end
          end
        end
        `ITC_MD_CAPT: begin
          if (run_ff && tick) begin
            nxt_cnt = cnt_ff + 16'h0001; // R11
            expire  = (cnt_ff == 16'hffff);
          end
        end
        `ITC_MD_ONEC: begin
          if (trig) begin
            nxt_cnt = cmp; // R10
            nxt_run = 1'b1;
            set_o   = 1'b1;
          end else if (run_ff && tick) begin
            if (cnt_ff == 16'h0000) begin
              nxt_run = 1'b0;
              expire  = 1'b1;
              clr_o   = 1'b1; // R10
            end else begin
              nxt_cnt = cnt_ff - 16'h0001;
            end
          end
        end
        default: begin
          nxt_run = 1'b0; // prohibited codes hold still
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 16'h0000;
      en_ff  <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      en_ff  <= nxt_en;
      run_ff <= nxt_run;
    end
  end

endmodule

// ---- hw/itc_top.v ----
// Functional notes
// R01: interrupt every compare plus one count periods
// R02: per-channel output level bits, low four bits
// R03: gate zero: software level drives pin
// R04: gate one: timer drives level, writes ignored
// R05: request flag bit 4 shows pending request
// R06: mask bit 4: zero enables, one blocks
// R07: start trigger one sets enable status
// R08: start trigger zero does nothing
// R09: count start depends on channel mode
// R10: master and slave channel pair make PWM
// R11: mode 000 counts down, 010 counts up
// R12: start-interrupt select fires irq and toggle
// R13: source select: operation clock or pin edges
// R14: expiry sets flag, reloads; zero write clears
//
// The AXI4-Lite register port and the address map were left to the implementer.

`include "itc_defines.vh"

module itc_top #(
  parameter ADDR_W = 12
) (
  input  wire                aclk,
  input  wire                aresetn,
  input  wire [ADDR_W-1:0]   awaddr,
  input  wire                awvalid,
  output wire                awready,
  input  wire [31:0]         wdata,
  input  wire [3:0]          wstrb,
  input  wire                wvalid,
  output wire                wready,
  output wire [1:0]          bresp,
  output wire                bvalid,
  input  wire                bready,
  input  wire [ADDR_W-1:0]   araddr,
  input  wire                arvalid,
  output wire                arready,
  output wire [31:0]         rdata,
  output wire [1:0]          rresp,
  output wire                rvalid,
  input  wire                rready,
  input  wire [`ITC_NCH-1:0] timer_input_pin,
  output wire [`ITC_NCH-1:0] timer_output_pin,
  output wire                channel_interval_interrupt
);

  localparam N = `ITC_NCH;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [ADDR_W-1:0] aw_addr_ff;
  reg               aw_full_ff;
  reg  [15:0]       w_data_ff;
  reg  [1:0]        w_strb_ff;
  reg               w_full_ff;
  reg               bvalid_ff;
  reg  [1:0]        bresp_ff;
  reg               rvalid_ff;
  reg  [31:0]       rdata_ff;
  reg  [1:0]        rresp_ff;
  reg  [31:0]       nxt_rdata;
  reg               rd_hit;
  reg               wr_hit;

  reg  [15:0]       cmp_ff  [0:N-1];
  reg  [15:0]       mode_ff [0:N-1];
  reg  [N-1:0]      lvl_ff;
  reg  [N-1:0]      gate_ff;
  reg  [N-1:0]      flag_ff;
  reg  [N-1:0]      mask_ff;
  reg  [15:0]       presc_ff;
  reg  [N-1:0]      pin_s1_ff;
  reg  [N-1:0]      pin_s2_ff;
  reg  [N-1:0]      pin_s3_ff;

  wire              wr_go;
  wire [15:0]       wmask;
  wire [15:0]       wval;
  wire [ADDR_W-1:0] wa;
  wire [ADDR_W-1:0] ra;
  wire [1:0]        wch;
  wire [1:0]        rch;
  wire              wr_cmp;
  wire              wr_mode;
  wire              wr_lvl;
  wire              wr_gate;
  wire              wr_start;
  wire              wr_stop;
  wire              wr_flag;
  wire              wr_mask;
  wire [3:0]        tap;
  wire [N-1:0]      tick;
  wire [N-1:0]      start;
  wire [N-1:0]      stop;
  wire [N-1:0]      en;
  wire [N-1:0]      expire;
  wire [N-1:0]      sevt;
  wire [N-1:0]      set_e;
  wire [N-1:0]      clr_e;
  wire [N-1:0]      tog_e;
  wire [N-1:0]      pin_edge;
  wire [16*N-1:0]   cnt_bus;

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign awready = !aw_full_ff && !bvalid_ff;
  assign wready  = !w_full_ff && !bvalid_ff;
  assign wr_go   = aw_full_ff && w_full_ff && !bvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= {ADDR_W{1'b0}};
      aw_full_ff <= 1'b0;
      w_data_ff  <= 16'h0000;
      w_strb_ff  <= 2'h0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `ITC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_ff <= awaddr;
        aw_full_ff <= 1'b1;
      end
      if (wvalid && wready) begin
        w_data_ff <= wdata[15:0];
        w_strb_ff <= wstrb[1:0];
        w_full_ff <= 1'b1;
      end
      if (wr_go) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode; byte lanes above bit 15 hold nothing
  // ----------------------------------------------------------------
  assign wa       = aw_addr_ff;
  assign wch      = wa[3:2];
  assign wmask    = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  assign wval     = w_data_ff & wmask;
  assign wr_cmp   = wr_go && ({wa[ADDR_W-1:4], 4'h0} == `ITC_OFS_CMP);
  assign wr_mode  = wr_go && ({wa[ADDR_W-1:4], 4'h0} == `ITC_OFS_MODE);
  assign wr_lvl   = wr_go && (wa == `ITC_OFS_LVL);
  assign wr_gate  = wr_go && (wa == `ITC_OFS_GATE);
  assign wr_start = wr_go && (wa == `ITC_OFS_START);
  assign wr_stop  = wr_go && (wa == `ITC_OFS_STOP);
  assign wr_flag  = wr_go && (wa == `ITC_OFS_FLAG);
  assign wr_mask  = wr_go && (wa == `ITC_OFS_MASK);

  // address check for the write answer
  always @* begin
    wr_hit = wr_cmp || wr_mode || wr_lvl || wr_gate || wr_start || wr_stop || wr_flag || wr_mask;
    if (wa[1:0] != 2'h0) begin
      wr_hit = 1'b0;
    end
  end

  // start and stop pulses; a zero bit is no trigger
  assign start = wr_start ? wval[N-1:0] : {N{1'b0}}; // R08
  assign stop  = wr_stop ? wval[N-1:0] : {N{1'b0}};

  // ----------------------------------------------------------------
  // read channel: one cycle from address to data
  // ----------------------------------------------------------------
  assign arready = !rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign ra      = araddr;
  assign rch     = ra[3:2];

  // read mux
  always @* begin
    nxt_rdata = 32'h0000_0000;
    rd_hit    = (ra[1:0] == 2'h0);
    if ({ra[ADDR_W-1:4], 4'h0} == `ITC_OFS_CMP) begin
      nxt_rdata[15:0] = cmp_ff[rch];
    end else if ({ra[ADDR_W-1:4], 4'h0} == `ITC_OFS_MODE) begin
      nxt_rdata[15:0] = mode_ff[rch];
    end else if ({ra[ADDR_W-1:4], 4'h0} == `ITC_OFS_CNT) begin
      nxt_rdata[15:0] = cnt_bus[16*rch +: 16];
    end else if (ra == `ITC_OFS_LVL) begin
      nxt_rdata[N-1:0] = lvl_ff;
    end else if (ra == `ITC_OFS_GATE) begin
      nxt_rdata[N-1:0] = gate_ff;
    end else if (ra == `ITC_OFS_START || ra == `ITC_OFS_STOP) begin
      nxt_rdata = 32'h0000_0000; // trigger registers read zero
    end else if (ra == `ITC_OFS_ENST) begin
      nxt_rdata[N-1:0] = en;
    end else if (ra == `ITC_OFS_FLAG) begin
      nxt_rdata[`ITC_FLAG_MSB:`ITC_FLAG_LSB] = flag_ff; // R05
    end else if (ra == `ITC_OFS_MASK) begin
      nxt_rdata[`ITC_FLAG_MSB:`ITC_FLAG_LSB] = mask_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read data register
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `ITC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_hit ? nxt_rdata : 32'h0000_0000;
      rresp_ff  <= rd_hit ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // operation clock prescaler and pin synchroniser
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      presc_ff  <= 16'h0000;
      pin_s1_ff <= {N{1'b0}};
      pin_s2_ff <= {N{1'b0}};
      pin_s3_ff <= {N{1'b0}};
    end else begin
      presc_ff  <= presc_ff + 16'h0001;
      pin_s1_ff <= timer_input_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // four operation clock taps
  assign tap[0] = ((presc_ff & `ITC_TAP0) == `ITC_TAP0);
  assign tap[1] = ((presc_ff & `ITC_TAP1) == `ITC_TAP1);
  assign tap[2] = ((presc_ff & `ITC_TAP2) == `ITC_TAP2);
  assign tap[3] = ((presc_ff & `ITC_TAP3) == `ITC_TAP3);

  // rising edges seen after the second flop only
  assign pin_edge = pin_s2_ff & ~pin_s3_ff;

  // ----------------------------------------------------------------
  // per-channel registers and count engines
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_ch
      wire [1:0] cks = mode_ff[i][`ITC_MODE_CKS_HI:`ITC_MODE_CKS_LO];

      // count source: operation clock tap or pin edge
      assign tick[i] = mode_ff[i][`ITC_MODE_CCS] ? pin_edge[i] : tap[cks]; // R13

      // compare and mode registers
      always @(posedge aclk) begin
        if (!aresetn) begin
          cmp_ff[i]  <= `ITC_RST_CMP;
          mode_ff[i] <= `ITC_RST_MODE;
        end else begin
          if (wr_cmp && wch == i) begin
            cmp_ff[i] <= (cmp_ff[i] & ~wmask) | wval;
          end
          if (wr_mode && wch == i) begin
            mode_ff[i] <= (mode_ff[i] & ~wmask) | wval;
          end
        end
      end

      // output level bit: timer owns it while gated on
      always @(posedge aclk) begin
        if (!aresetn) begin
          lvl_ff[i] <= 1'b0;
        end else if (gate_ff[i]) begin
          if (set_e[i]) begin
            lvl_ff[i] <= 1'b1; // R04
          end else if (clr_e[i]) begin
            lvl_ff[i] <= 1'b0; // R04
          end else if (tog_e[i]) begin
            lvl_ff[i] <= ~lvl_ff[i]; // R04
          end
        end else if (wr_lvl && w_strb_ff[0]) begin
          lvl_ff[i] <= w_data_ff[i]; // R03
        end
      end

      // interval request flag: set wins over a zero write
      always @(posedge aclk) begin
        if (!aresetn) begin
          flag_ff[i] <= 1'b0;
        end else if (expire[i] || sevt[i]) begin
          flag_ff[i] <= 1'b1; // R14
        end else if (wr_flag && w_strb_ff[0] && !w_data_ff[`ITC_FLAG_LSB+i]) begin
          flag_ff[i] <= 1'b0; // R14
        end
      end

      // count engine; channel 0 expiry is the pair master
      itc_chan u_chan (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick[i]),
        .start     (start[i]),
        .stop      (stop[i]),
        .trig      (expire[0]),
        .mode      (mode_ff[i][`ITC_MODE_MD_HI:0]),
        .cmp       (cmp_ff[i]),
        .cnt       (cnt_bus[16*i +: 16]),
        .en        (en[i]),
        .expire    (expire[i]),
        .start_evt (sevt[i]),
        .set_o     (set_e[i]),
        .clr_o     (clr_e[i]),
        .tog_o     (tog_e[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // gate and mask registers
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      gate_ff <= `ITC_RST_GATE;
      mask_ff <= `ITC_RST_MASK;
    end else begin
      if (wr_gate && w_strb_ff[0]) begin
        gate_ff <= w_data_ff[N-1:0];
      end
      if (wr_mask && w_strb_ff[0]) begin
        mask_ff <= w_data_ff[`ITC_FLAG_MSB:`ITC_FLAG_LSB]; // R06
      end
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt
  // ----------------------------------------------------------------
  assign timer_output_pin = lvl_ff; // R02

  // one level line, high while an unmasked flag is set
  assign channel_interval_interrupt = |(flag_ff & ~mask_ff); // R06

endmodule

// ---- dv/itc_props.sv ----
`include "itc_defines.vh"

module itc_props #(
  parameter ADDR_W = 12
) (
  input wire                aclk,
  input wire                aresetn,
  input wire [ADDR_W-1:0]   awaddr,
  input wire                awvalid,
  input wire                awready,
  input wire [31:0]         wdata,
  input wire [3:0]          wstrb,
  input wire                wvalid,
  input wire                wready,
  input wire [1:0]          bresp,
  input wire                bvalid,
  input wire                bready,
  input wire [ADDR_W-1:0]   araddr,
  input wire                arvalid,
  input wire                arready,
  input wire [31:0]         rdata,
  input wire [1:0]          rresp,
  input wire                rvalid,
  input wire                rready,
  input wire [`ITC_NCH-1:0] timer_input_pin,
  input wire [`ITC_NCH-1:0] timer_output_pin,
  input wire                channel_interval_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // handshake steps
  // ----------------------------------------------------------------
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  sequence s_b_wait;
    bvalid && !bready;
  endsequence
  sequence s_r_wait;
    rvalid && !rready;
  endsequence

  // ----------------------------------------------------------------
  // bus and output relations
  // ----------------------------------------------------------------
  AST_WR_ANSWER: assert property (s_wr_taken |-> ##2 bvalid) else $error("write response missing");
  AST_RD_ANSWER: assert property (s_rd_taken |=> rvalid) else $error("read response missing");
  AST_B_HOLD: assert property (s_b_wait |=> bvalid && $stable(bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_r_wait |=> rvalid && $stable(rdata) && $stable(rresp)) else $error("read data moved");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid) else $error("write response repeated");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid) else $error("read response repeated");
  AST_W_REFUSE: assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
  AST_R_ERR_ZERO: assert property (rvalid && rresp == `ITC_RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read data not zero");
  AST_RESET_OUT: assert property ($rose(aresetn) |-> !channel_interval_interrupt && timer_output_pin == 4'h0)
    else $error("outputs not idle after reset");
endmodule

bind itc_top itc_props #(.ADDR_W(ADDR_W)) u_itc_props (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
  .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin),
  .channel_interval_interrupt(channel_interval_interrupt)
);

// ---- dv/tb_top.sv ----
`include "itc_defines.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [3:0]  tin;
  wire         awready;
  wire         wready;
  wire         bvalid;
  wire         arready;
  wire         rvalid;
  wire         irq;
  wire [1:0]   bresp;
  wire [1:0]   rresp;
  wire [31:0]  rdata;
  wire [3:0]   tout;
  integer      n_errors;
  integer      n_compared;
  integer      seed;
  integer      cyc = 0;
  integer      t0;
  integer      t1;
  integer      k;
  integer      i;
  logic [31:0] d;
  logic [31:0] c1;
  logic [1:0]  r;
  logic [15:0] cv;
  logic [11:0] rst_a [8] = '{`ITC_OFS_MASK, `ITC_OFS_FLAG, `ITC_OFS_LVL, `ITC_OFS_GATE, `ITC_OFS_CMP,
                             `ITC_OFS_MODE, `ITC_OFS_START, `ITC_OFS_ENST};

  itc_top u_itc_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer_input_pin(tin), .timer_output_pin(tout), .channel_interval_interrupt(irq)
  );

  // ----------------------------------------------------------------
  // clock, cycle count, watchdog
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  initial begin
    #(20000 * 50);
    n_errors = n_errors + 1;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [11:0] a, input logic [31:0] v);
    wr(a, v);
    chk("bresp", 32'(`ITC_RESP_OKAY), 32'(r));
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, d);
  endtask
  task automatic wait_irq(output integer t);
    integer n;
    n = 0;
    do begin
      @(posedge aclk);
      n = n + 1;
    end while (irq !== 1'b1 && n < 2000);
    if (irq !== 1'b1) n_errors = n_errors + 1;
    t = cyc;
  endtask
  task automatic pin_edge;
    @(posedge aclk);
    tin <= 4'h1;
    repeat (4) @(posedge aclk);
    tin <= 4'h0;
    repeat (6) @(posedge aclk);
  endtask
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32;
    n_errors = 0;
    n_compared = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb, tin} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) rd_chk("reset value", rst_a[i], (i == 0) ? 32'h000000f0 : 32'h0);
    wr(12'h100, 32'h1);
    chk("unmapped bresp", 32'(`ITC_RESP_SLVERR), 32'(r));
    rd(12'h002);
    chk("misaligned rresp", 32'(`ITC_RESP_SLVERR), 32'(r));
    // software level with gate low, then ignored with gate high
    cv = 16'($random(seed));
    wr_ok(`ITC_OFS_LVL, 32'(cv[3:0]));
    chk("pins", 32'(cv[3:0]), 32'(tout));
    wr_ok(`ITC_OFS_GATE, 32'hf);
    wr_ok(`ITC_OFS_LVL, 32'(~cv[3:0]));
    chk("pins gated", 32'(cv[3:0]), 32'(tout));
    wr_ok(`ITC_OFS_GATE, 32'h0);
    wr_ok(`ITC_OFS_LVL, 32'h0);
    // interval period on two clock taps
    wr_ok(`ITC_OFS_MASK, 32'he0);
    for (k = 0; k < 2; k = k + 1) begin
      cv = 16'd20 + 16'($random(seed) & 32'h1f);
      wr_ok(`ITC_OFS_CMP, 32'(cv));
      wr_ok(`ITC_OFS_MODE, 32'(k) << 14);
      wr_ok(`ITC_OFS_START, 32'h1);
      wr_ok(`ITC_OFS_START, 32'h0);
      rd_chk("enable status", `ITC_OFS_ENST, 32'h1);
      wait_irq(t0);
      wr_ok(`ITC_OFS_FLAG, 32'h0);
      chk("irq cleared", 32'h0, 32'(irq));
      wait_irq(t1);
      chk("period", (32'(cv) + 1) * ((k == 1) ? 4 : 1), 32'(t1 - t0));
      wr_ok(`ITC_OFS_STOP, 32'h1);
      wr_ok(`ITC_OFS_FLAG, 32'h0);
    end
    // pending flag with mask set and cleared
    wr_ok(`ITC_OFS_CMP, 32'h3);
    wr_ok(`ITC_OFS_MODE, 32'h0);
    wr_ok(`ITC_OFS_MASK, 32'hf0);
    wr_ok(`ITC_OFS_START, 32'h1);
    repeat (20) @(posedge aclk);
    wr_ok(`ITC_OFS_STOP, 32'h1);
    rd_chk("flag pending", `ITC_OFS_FLAG, 32'h10);
    chk("irq masked", 32'h0, 32'(irq));
    wr_ok(`ITC_OFS_MASK, 32'he0);
    chk("irq unmasked", 32'h1, 32'(irq));
    wr_ok(`ITC_OFS_START, 32'h0);
    rd_chk("enable status", `ITC_OFS_ENST, 32'h0);
    wr_ok(`ITC_OFS_FLAG, 32'h0);
    rd_chk("flag cleared", `ITC_OFS_FLAG, 32'h0);
    // start interrupt select: on, then off
    wr_ok(`ITC_OFS_GATE, 32'h1);
    wr_ok(`ITC_OFS_CMP, 32'hfff);
    for (k = 1; k >= 0; k = k - 1) begin
      wr_ok(`ITC_OFS_MODE, 32'(k));
      wr_ok(`ITC_OFS_START, 32'h1);
      repeat (3) @(posedge aclk);
      chk("start irq", 32'(k), 32'(irq));
      chk("start toggle", 32'h1, 32'(tout[0]));
      wr_ok(`ITC_OFS_STOP, 32'h1);
      wr_ok(`ITC_OFS_FLAG, 32'h0);
    end
    // count direction: interval down, capture up
    for (k = 0; k < 2; k = k + 1) begin
      wr_ok(`ITC_OFS_MODE, (k == 1) ? 32'h4 : 32'h0);
      wr_ok(`ITC_OFS_START, 32'h1);
      rd(`ITC_OFS_CNT);
      c1 = d;
      rd(`ITC_OFS_CNT);
      chk("count direction", 32'h1, (k == 1) ? 32'(d > c1) : 32'(d < c1));
      wr_ok(`ITC_OFS_STOP, 32'h1);
    end
    // paired pulse: channel 0 sets the period, channel 1 the width
    wr_ok(`ITC_OFS_CMP, 32'h1f);
    wr_ok(`ITC_OFS_MODE, 32'h0);
    wr_ok(`ITC_OFS_CMP + 12'h4, 32'h5);
    wr_ok(`ITC_OFS_MODE + 12'h4, 32'h8);
    wr_ok(`ITC_OFS_GATE, 32'h2);
    wr_ok(`ITC_OFS_START, 32'h3);
    wait_irq(t0);
    chk("pulse start", 32'h1, 32'(tout[1]));
    repeat (5) @(posedge aclk);
    chk("pulse high", 32'h1, 32'(tout[1]));
    @(posedge aclk);
    chk("pulse end", 32'h0, 32'(tout[1]));
    // pin edges as count source
    wr_ok(`ITC_OFS_MODE, 32'h1000);
    wr_ok(`ITC_OFS_START, 32'h1);
    pin_edge();
    rd(`ITC_OFS_CNT);
    c1 = d;
    repeat (20) @(posedge aclk);
    rd_chk("count still", `ITC_OFS_CNT, c1);
    pin_edge();
    pin_edge();
    rd_chk("count edges", `ITC_OFS_CNT, c1 - 32'h2);
    print_verdict();
  end
endmodule
